/* csl_pkg.sv */
// Purpose: Shared constants and types of the configuration stream loader
// Assumes: 40 MHz reference clock, 8 MHz nominal internal oscillator
// Notes:   All timing counts derive from their figures in their own unit
package csl_pkg;
  // Clock rates
  localparam int CLK_KHZ      = 40000;
  localparam int OSC_KHZ      = 8000;
  localparam int OSC_CYC      = CLK_KHZ / OSC_KHZ;
  // Power-on delay, nominal, and the factor applied when mode bit zero is low
  localparam int POR_US       = 16000;
  localparam int POR_CYC      = POR_US * (CLK_KHZ / 1000);
  localparam int POR_MASTER_X = 4;
  // Least delay before a released init line counts as inactive
  localparam int INIT_DLY_US  = 50;
  localparam int INIT_DLY_CYC = (INIT_DLY_US * CLK_KHZ + 999) / 1000;
  localparam int MODE_SMP_CYC = 2;
  // Stream layout
  localparam int LEN_W        = 24;
  localparam int CHK_W        = 4;
  localparam int LAST_SPAN    = 7;
  localparam int ADDR_W       = 18;
  localparam int DIV_W        = 20;
  localparam int TAP0         = 4;
  localparam int TAP1         = 9;
  localparam int TAP2         = 14;
  localparam int TAP3         = 19;
  localparam logic [3:0]  PREAMBLE      = 4'h2;
  localparam logic [3:0]  EOF_CODE      = 4'h6;
  localparam logic [17:0] ADDR_UP_START = 18'h00000;
  localparam logic [17:0] ADDR_DN_START = 18'h3ffff;
  // Mode pin codes {bit2,bit1,bit0}
  localparam logic [2:0]  MC_MS  = 3'h0;
  localparam logic [2:0]  MC_SS  = 3'h7;
  localparam logic [2:0]  MC_SPS = 3'h3;
  localparam logic [2:0]  MC_SPA = 3'h5;
  localparam logic [2:0]  MC_MPU = 3'h6;
  localparam logic [2:0]  MC_MPD = 3'h4;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_LEN  = 12'h008;
  localparam logic [11:0] REG_CCNT = 12'h00c;
  typedef enum logic [2:0] {MD_MS, MD_MPU, MD_MPD, MD_SPS, MD_SPA, MD_SS, MD_RSV} csl_mode_t;
  typedef enum logic [3:0] {ST_CLEAR, ST_LAST, ST_INITW, ST_DLY, ST_SMP, ST_CFG, ST_ERR, ST_UP} csl_state_t;
  typedef enum logic [2:0] {PS_HDR, PS_LEN, PS_SEP, PS_START, PS_DATA, PS_CHK, PS_PASS} csl_pst_t;
  typedef struct packed {
    logic [1:0] tap_b_sel;
    logic [1:0] tap_a_sel;
    logic       crc_en;
    logic       osc_run;
  } csl_ctrl_t;
  localparam csl_ctrl_t CTRL_RST = '{tap_b_sel: 2'h1, tap_a_sel: 2'h0, crc_en: 1'b0, osc_run: 1'b0};
  typedef struct packed {
    logic [21:0] rsv;
    logic        up;
    logic        err;
    logic        rdy;
    csl_mode_t   mode;
    csl_state_t  st;
  } csl_stat_t;
  typedef struct packed {
    logic vld;
    logic val;
  } csl_bit_t;
endpackage

/* csl_top.sv */
// Purpose: Configuration stream loader: memory clear, mode pick, bitstream parse, daisy chain
// Assumes: Configuration pins asynchronous to REF_CLK, APB synchronous to it; frame memory itself lies outside
// Notes:   Bits are taken most significant first from each parallel byte
// Contract
// - Resynchronized divider taps at bits 4,9,14,19
// - Oscillator net driven only when run bit set
// - Decode three mode pins into six modes
// - Mode pins become user pins after configuration
// - Master parallel makes clock, addresses, serializes bytes
// - Peripheral modes take bytes with ready status
// - Async peripheral bursts clocks; sync uses external
// - Slave captures rising, re-emits on falling edge
// - Header: ones, 0010, 24-bit length, separator
// - Frame: zero start, data, four check bits
// - Without CRC each frame ends with 0110
// - CRC checked per frame; last spans eleven
// - Frame error halts load, init low, clocks run
// - Pass header through, latch length after preamble
// - Output held high until own frames loaded
// - Start up when clock count equals length
// - Power-on delay 16 ms, fourfold when bit0 low
// - Clear memory while delay or program active
// - After clean pass, one more, then test init
// - Eight postamble bits accepted in counted stream
// - Sample mode pins two clocks after init high
// - Master modes wait 50 us on init release
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module csl_top #(
  parameter int         POR_CYCLES = csl_pkg::POR_CYC,
  parameter int         FRAME_BITS = 97,
  parameter int         NUM_FRAMES = 310,
  parameter logic [3:0] CRC_POLY   = 4'h3,
  parameter logic [3:0] CRC_INIT   = 4'hf
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PROGRAM_B,
  input  wire logic        INIT_I,
  output logic             INIT_O,
  output logic             INIT_OE,
  input  wire logic        MODE_BIT0_I,
  input  wire logic        MODE_BIT1_I,
  input  wire logic        MODE_BIT2_I,
  output logic             MODE_BIT1_O,
  output logic             MODE_BIT1_OE,
  input  wire logic        CONFIG_CLOCK_I,
  output logic             CONFIG_CLOCK_O,
  output logic             CONFIG_CLOCK_OE,
  input  wire logic        DIN,
  output logic             DOUT,
  input  wire logic [7:0]  DATA_IN,
  output logic      [17:0] PROM_ADDR,
  input  wire logic        PERIPH_WR_B,
  output logic             PERIPH_READY,
  output logic             STARTUP,
  output logic             OSC_OUT_NET,
  output logic             DIVIDER_TAP_A,
  output logic             DIVIDER_TAP_B,
  output logic             MODE_BIT0_USER_IN,
  output logic             MODE_BIT2_USER_IN,
  input  wire logic        MODE_BIT1_USER_OUT,
  input  wire logic        MODE_BIT1_USER_OE
);
  localparam logic [21:0] POR_LIM1 = 22'(POR_CYCLES);
  localparam logic [21:0] POR_LIM4 = 22'(POR_CYCLES * csl_pkg::POR_MASTER_X);

  logic [15:0]         s1_ff;
  logic [15:0]         s2_ff;
  logic                xclk_prev_ff;
  logic                wr_prev_ff;
  logic [3:0]          osc_cnt_ff;
  logic [19:0]         div_ff;
  logic [3:0]          tap_ff;
  logic [21:0]         por_cnt_ff;
  csl_pkg::csl_state_t state_ff;
  csl_pkg::csl_state_t nxt_state;
  csl_pkg::csl_mode_t  mode_ff;
  logic [15:0]         fa_ff;
  logic [11:0]         dly_ff;
  logic                config_clock_ff;
  logic [7:0]          sh_ff;
  logic [3:0]          pend_ff;
  logic [17:0]         addr_ff;
  csl_pkg::csl_pst_t   pst_ff;
  csl_pkg::csl_pst_t   nxt_pst;
  logic [3:0]          hdr_ff;
  logic [3:0]          nxt_hdr;
  logic [23:0]         len_ff;
  logic [23:0]         nxt_len;
  logic [15:0]         bcnt_ff;
  logic [15:0]         nxt_bcnt;
  logic [15:0]         fcnt_ff;
  logic [15:0]         nxt_fcnt;
  logic [3:0]          crc_ff;
  logic [3:0]          nxt_crc;
  logic [3:0]          chk_ff;
  logic [3:0]          nxt_chk;
  logic                err_ff;
  logic                nxt_err;
  logic [23:0]         ccnt_ff;
  logic                dnext_ff;
  csl_pkg::csl_ctrl_t  ctrl_ff;

  // Pin synchronizer, two stages
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s1_ff <= 16'h0000;
      s2_ff <= 16'h0000;
    end
    else
    begin
      s1_ff <= {PROGRAM_B, INIT_I, MODE_BIT2_I, MODE_BIT1_I, MODE_BIT0_I, CONFIG_CLOCK_I, DIN, PERIPH_WR_B, DATA_IN};
      s2_ff <= s1_ff;
    end
  end

  // Synchronized pin views and edges
  wire       prog_b_s = s2_ff[15];
  wire       init_s   = s2_ff[14];
  wire [2:0] mode_s   = s2_ff[13:11];
  wire       xclk_s   = s2_ff[10];
  wire       din_s    = s2_ff[9];
  wire       wr_b_s   = s2_ff[8];
  wire [7:0] data_s   = s2_ff[7:0];
  wire       xrise    = xclk_s & ~xclk_prev_ff;
  wire       xfall    = ~xclk_s & xclk_prev_ff;
  wire       wr_fall  = ~wr_b_s & wr_prev_ff;

  // Mode decode of the pins and of the sampled mode
  wire csl_pkg::csl_mode_t mode_dec =
    (mode_s == csl_pkg::MC_MS)  ? csl_pkg::MD_MS  :
    (mode_s == csl_pkg::MC_SS)  ? csl_pkg::MD_SS  :
    (mode_s == csl_pkg::MC_SPS) ? csl_pkg::MD_SPS :
    (mode_s == csl_pkg::MC_SPA) ? csl_pkg::MD_SPA :
    (mode_s == csl_pkg::MC_MPU) ? csl_pkg::MD_MPU :
    (mode_s == csl_pkg::MC_MPD) ? csl_pkg::MD_MPD : csl_pkg::MD_RSV;
  wire m_par    = (mode_ff == csl_pkg::MD_MPU) | (mode_ff == csl_pkg::MD_MPD);
  wire m_master = m_par | (mode_ff == csl_pkg::MD_MS);
  wire m_spa    = mode_ff == csl_pkg::MD_SPA;
  wire m_sps    = mode_ff == csl_pkg::MD_SPS;
  wire m_ext    = m_sps | (mode_ff == csl_pkg::MD_SS);
  wire m_serial = (mode_ff == csl_pkg::MD_MS) | (mode_ff == csl_pkg::MD_SS);

  // Internal oscillator and time-out divider
  wire osc_tick = osc_cnt_ff == 4'(csl_pkg::OSC_CYC - 1);
  wire osc_lvl  = osc_cnt_ff < 4'(csl_pkg::OSC_CYC / 2);
  wire [3:0] taps = {div_ff[csl_pkg::TAP3], div_ff[csl_pkg::TAP2], div_ff[csl_pkg::TAP1], div_ff[csl_pkg::TAP0]};
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      osc_cnt_ff <= 4'h0;
      div_ff     <= 20'h00000;
      tap_ff     <= 4'h0;
    end
    else
    begin
      osc_cnt_ff <= osc_tick ? 4'h0 : osc_cnt_ff + 4'h1;
      div_ff     <= osc_tick ? div_ff + 20'h00001 : div_ff;
      tap_ff     <= taps;
    end
  end

  // Power-on delay, longer when mode bit zero is low
  wire [21:0] por_lim  = mode_s[0] ? POR_LIM1 : POR_LIM4;
  wire        por_busy = por_cnt_ff < por_lim;
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      por_cnt_ff <= 22'h000000;
    else if (por_busy)
      por_cnt_ff <= por_cnt_ff + 22'h000001;
  end

  // Clearing pass over the frame addresses
  wire pass_end = osc_tick & (fa_ff == 16'(NUM_FRAMES - 1));
  wire cfg_act  = state_ff == csl_pkg::ST_CFG;
  wire len_hit  = cfg_act & (pst_ff == csl_pkg::PS_PASS) & (ccnt_ff == len_ff);

  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    if (!prog_b_s)
      nxt_state = csl_pkg::ST_CLEAR;
    else
    begin
      case (state_ff)
        csl_pkg::ST_CLEAR: if (pass_end && !por_busy) nxt_state = csl_pkg::ST_LAST;
        csl_pkg::ST_LAST:  if (pass_end) nxt_state = csl_pkg::ST_INITW;
        csl_pkg::ST_INITW: if (init_s) nxt_state = mode_s[0] ? csl_pkg::ST_SMP : csl_pkg::ST_DLY;
        csl_pkg::ST_DLY:   if (dly_ff == 12'(csl_pkg::INIT_DLY_CYC - 1)) nxt_state = csl_pkg::ST_SMP;
        csl_pkg::ST_SMP:   if (dly_ff == 12'(csl_pkg::MODE_SMP_CYC - 1)) nxt_state = csl_pkg::ST_CFG;
        csl_pkg::ST_CFG:   if (err_ff) nxt_state = csl_pkg::ST_ERR;
                           else if (len_hit) nxt_state = csl_pkg::ST_UP;
        default:           nxt_state = state_ff;
      endcase
    end
  end

  // Sequencer registers, mode sample and clear address
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_ff <= csl_pkg::ST_CLEAR;
      dly_ff   <= 12'h000;
      fa_ff    <= 16'h0000;
      mode_ff  <= csl_pkg::MD_RSV;
    end
    else
    begin
      state_ff <= nxt_state;
      dly_ff   <= (nxt_state != state_ff) ? 12'h000 : dly_ff + 12'h001;
      fa_ff    <= pass_end ? 16'h0000 : (osc_tick ? fa_ff + 16'h0001 : fa_ff);
      if (state_ff == csl_pkg::ST_SMP && nxt_state == csl_pkg::ST_CFG)
        mode_ff <= mode_dec;
    end
  end

  // Configuration clock: own clock in master and async peripheral modes
  wire run_st   = cfg_act | (state_ff == csl_pkg::ST_ERR) | (state_ff == csl_pkg::ST_UP);
  wire config_clock_run = run_st & (m_master | (m_spa & (pend_ff != 4'h0)));
  wire int_rise = osc_tick & config_clock_run & ~config_clock_ff;
  wire int_fall = osc_tick & config_clock_ff;
  wire tick     = m_ext ? xrise : int_rise;
  wire fall_t   = m_ext ? xfall : int_fall;

  // Bit extraction from serial pin or byte shifter
  wire load_now = tick & (pend_ff == 4'h0) & (m_par | m_sps);
  wire bit_in   = m_serial ? din_s : (load_now ? data_s[7] : sh_ff[7]);
  wire csl_pkg::csl_bit_t bev = '{vld: cfg_act & tick & (m_serial | load_now | (pend_ff != 4'h0)), val: bit_in};
  wire spa_take = cfg_act & m_spa & wr_fall & (pend_ff == 4'h0);

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      config_clock_ff      <= 1'b0;
      xclk_prev_ff <= 1'b0;
      wr_prev_ff   <= 1'b1;
      sh_ff        <= 8'h00;
      pend_ff      <= 4'h0;
    end
    else
    begin
      config_clock_ff      <= (osc_tick & (config_clock_run | config_clock_ff)) ? ~config_clock_ff : config_clock_ff;
      xclk_prev_ff <= xclk_s;
      wr_prev_ff   <= wr_b_s;
      if (!cfg_act)
        pend_ff <= 4'h0;
      else if (spa_take)
      begin
        sh_ff   <= data_s;
        pend_ff <= 4'h8;
      end
      else if (bev.vld && !m_serial)
      begin
        sh_ff   <= load_now ? {data_s[6:0], 1'b0} : {sh_ff[6:0], 1'b0};
        pend_ff <= load_now ? 4'h7 : pend_ff - 4'h1;
      end
    end
  end

  // PROM address: start at either end, step per byte fetched
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      addr_ff <= csl_pkg::ADDR_UP_START;
    else if (state_ff == csl_pkg::ST_SMP)
      addr_ff <= (mode_dec == csl_pkg::MD_MPD) ? csl_pkg::ADDR_DN_START : csl_pkg::ADDR_UP_START;
    else if (load_now && m_par)
      addr_ff <= (mode_ff == csl_pkg::MD_MPD) ? addr_ff - 18'h00001 : addr_ff + 18'h00001;
  end

  // Frame check helpers
  wire        b         = bev.val;
  wire        last_fr   = fcnt_ff == 16'(NUM_FRAMES - 1);
  wire [15:0] span      = last_fr ? 16'(csl_pkg::LAST_SPAN) : 16'h0000;
  wire [15:0] data_last = 16'(FRAME_BITS - 1) - span;
  wire [15:0] chk_last  = 16'(csl_pkg::CHK_W - 1) + span;
  wire [3:0]  crc_step  = {crc_ff[2:0], 1'b0} ^ ((crc_ff[3] ^ b) ? CRC_POLY : 4'h0);
  wire [3:0]  new_chk   = {chk_ff[2:0], b};
  wire        chk_ok    = ctrl_ff.crc_en ? (new_chk == crc_ff) : (new_chk == csl_pkg::EOF_CODE);

  // Bitstream parser next state
  always_comb
  begin
    nxt_pst  = pst_ff;
    nxt_hdr  = hdr_ff;
    nxt_len  = len_ff;
    nxt_bcnt = bcnt_ff;
    nxt_fcnt = fcnt_ff;
    nxt_crc  = crc_ff;
    nxt_chk  = chk_ff;
    nxt_err  = err_ff;
    if (state_ff == csl_pkg::ST_CLEAR)
    begin
      nxt_pst  = csl_pkg::PS_HDR;
      nxt_hdr  = 4'hf;
      nxt_bcnt = 16'h0000;
      nxt_fcnt = 16'h0000;
      nxt_crc  = CRC_INIT;
      nxt_err  = 1'b0;
    end
    else if (bev.vld)
    begin
      nxt_bcnt = bcnt_ff + 16'h0001;
      case (pst_ff)
        csl_pkg::PS_HDR:
        begin
          nxt_hdr  = {hdr_ff[2:0], b};
          nxt_bcnt = 16'h0000;
          if ({hdr_ff[2:0], b} == csl_pkg::PREAMBLE)
            nxt_pst = csl_pkg::PS_LEN;
        end
        csl_pkg::PS_LEN:
        begin
          nxt_len = {len_ff[22:0], b};
          if (bcnt_ff == 16'(csl_pkg::LEN_W - 1))
          begin
            nxt_pst  = csl_pkg::PS_SEP;
            nxt_bcnt = 16'h0000;
          end
        end
        csl_pkg::PS_SEP:
        begin
          if (!b)
            nxt_err = 1'b1;
          if (bcnt_ff == 16'(csl_pkg::CHK_W - 1))
          begin
            nxt_pst  = csl_pkg::PS_START;
            nxt_bcnt = 16'h0000;
          end
        end
        csl_pkg::PS_START:
        begin
          nxt_bcnt = 16'h0000;
          if (!b)
            nxt_pst = csl_pkg::PS_DATA;
          else if (ctrl_ff.crc_en)
            nxt_err = 1'b1;
        end
        csl_pkg::PS_DATA:
        begin
          nxt_crc = crc_step;
          if (bcnt_ff == data_last)
          begin
            nxt_pst  = csl_pkg::PS_CHK;
            nxt_bcnt = 16'h0000;
          end
        end
        csl_pkg::PS_CHK:
        begin
          if (bcnt_ff < span)
            nxt_crc = crc_step;
          else
            nxt_chk = new_chk;
          if (bcnt_ff == chk_last)
          begin
            nxt_bcnt = 16'h0000;
            if (!chk_ok)
              nxt_err = 1'b1;
            else if (last_fr)
              nxt_pst = csl_pkg::PS_PASS;
            else
            begin
              nxt_pst  = csl_pkg::PS_START;
              nxt_fcnt = fcnt_ff + 16'h0001;
            end
          end
        end
        default: nxt_bcnt = bcnt_ff;
      endcase
    end
  end

  // Parser registers and configuration clock count
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pst_ff   <= csl_pkg::PS_HDR;
      hdr_ff   <= 4'hf;
      len_ff   <= 24'h000000;
      bcnt_ff  <= 16'h0000;
      fcnt_ff  <= 16'h0000;
      crc_ff   <= CRC_INIT;
      chk_ff   <= 4'h0;
      err_ff   <= 1'b0;
      ccnt_ff  <= 24'h000000;
      dnext_ff <= 1'b1;
    end
    else
    begin
      pst_ff  <= nxt_pst;
      hdr_ff  <= nxt_hdr;
      len_ff  <= nxt_len;
      bcnt_ff <= nxt_bcnt;
      fcnt_ff <= nxt_fcnt;
      crc_ff  <= nxt_crc;
      chk_ff  <= nxt_chk;
      err_ff  <= nxt_err;
      if (state_ff == csl_pkg::ST_CLEAR)
        ccnt_ff <= 24'h000000;
      else if (cfg_act && tick)
        ccnt_ff <= ccnt_ff + 24'h000001;
      if (bev.vld)
        dnext_ff <= (pst_ff == csl_pkg::PS_HDR || pst_ff == csl_pkg::PS_LEN || pst_ff == csl_pkg::PS_PASS)
                    ? b : 1'b1;
    end
  end

  // APB decode and read selection
  wire        apb_acc = PSEL & PENABLE;
  wire        apb_cmp = apb_acc & PREADY;
  wire        hit     = (PADDR == csl_pkg::REG_CTRL) | (PADDR == csl_pkg::REG_STAT) |
                        (PADDR == csl_pkg::REG_LEN) | (PADDR == csl_pkg::REG_CCNT);
  wire csl_pkg::csl_stat_t stat_w = '{rsv: 22'h000000, up: state_ff == csl_pkg::ST_UP, err: err_ff,
                                      rdy: PERIPH_READY, mode: mode_ff, st: state_ff};
  wire [31:0] rd_w =
    (PADDR == csl_pkg::REG_CTRL) ? {26'h0000000, ctrl_ff} :
    (PADDR == csl_pkg::REG_STAT) ? stat_w :
    (PADDR == csl_pkg::REG_LEN)  ? {8'h00, len_ff} :
    (PADDR == csl_pkg::REG_CCNT) ? {8'h00, ccnt_ff} : 32'h00000000;

  // APB slave: one wait state on every access
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      ctrl_ff <= csl_pkg::CTRL_RST;
    end
    else
    begin
      PREADY  <= apb_acc & ~PREADY;
      PSLVERR <= apb_acc & ~PREADY & ~hit;
      PRDATA  <= (apb_acc && !PREADY && !PWRITE) ? rd_w : 32'h00000000;
      if (apb_cmp && PWRITE && PADDR == csl_pkg::REG_CTRL)
        ctrl_ff <= PWDATA[5:0];
    end
  end

  // Pin and net outputs
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      INIT_O            <= 1'b0;
      INIT_OE           <= 1'b1;
      DOUT              <= 1'b1;
      CONFIG_CLOCK_O    <= 1'b0;
      CONFIG_CLOCK_OE   <= 1'b0;
      PROM_ADDR         <= csl_pkg::ADDR_UP_START;
      PERIPH_READY      <= 1'b0;
      STARTUP           <= 1'b0;
      OSC_OUT_NET       <= 1'b0;
      DIVIDER_TAP_A     <= 1'b0;
      DIVIDER_TAP_B     <= 1'b0;
      MODE_BIT0_USER_IN <= 1'b0;
      MODE_BIT2_USER_IN <= 1'b0;
      MODE_BIT1_O       <= 1'b0;
      MODE_BIT1_OE      <= 1'b0;
    end
    else
    begin
      INIT_O            <= 1'b0;
      INIT_OE           <= (nxt_state == csl_pkg::ST_CLEAR) | (nxt_state == csl_pkg::ST_LAST) |
                           (nxt_state == csl_pkg::ST_ERR);
      if (fall_t)
        DOUT <= dnext_ff;
      CONFIG_CLOCK_O    <= config_clock_ff;
      CONFIG_CLOCK_OE   <= run_st & (m_master | m_spa);
      PROM_ADDR         <= addr_ff;
      PERIPH_READY      <= cfg_act & (m_spa | m_sps) & (pend_ff == 4'h0) & ~spa_take;
      STARTUP           <= nxt_state == csl_pkg::ST_UP;
      OSC_OUT_NET       <= osc_lvl & ctrl_ff.osc_run;
      DIVIDER_TAP_A     <= tap_ff[ctrl_ff.tap_a_sel];
      DIVIDER_TAP_B     <= tap_ff[ctrl_ff.tap_b_sel];
      MODE_BIT0_USER_IN <= (state_ff == csl_pkg::ST_UP) & mode_s[0];
      MODE_BIT2_USER_IN <= (state_ff == csl_pkg::ST_UP) & mode_s[2];
      MODE_BIT1_O       <= MODE_BIT1_USER_OUT;
      MODE_BIT1_OE      <= (state_ff == csl_pkg::ST_UP) & MODE_BIT1_USER_OE;
    end
  end
endmodule // csl_top
`default_nettype wire

/* csl_checker.sv */
// Purpose: Port assertions of the stream loader
// Assumes: Bound to csl_top
// Notes:   APB answers after one wait state
`timescale 1ns/10ps
`default_nettype none
module csl_checker (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        INIT_O,
  input wire logic        INIT_OE,
  input wire logic        STARTUP,
  input wire logic        MODE_BIT0_USER_IN,
  input wire logic        MODE_BIT1_OE
);
  // One domain, reset disables all
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  apb_wait_a: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY) else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error alone");
  unmapped_err_a: assert property (PSEL && PREADY && PADDR > 12'h00c |-> PSLVERR) else $error("no error");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stray data");
  init_drain_a: assert property (INIT_O == 1'b0) else $error("init driven high");
  user_in_a: assert property (!STARTUP [*3] |-> !MODE_BIT0_USER_IN) else $error("user in early");
  user_oe_a: assert property (!STARTUP [*3] |-> !MODE_BIT1_OE) else $error("user oe early");
  up_release_a: assert property (STARTUP |-> !INIT_OE) else $error("init low in startup");
  // Main scenarios
  cover property (PREADY && PSLVERR);
  cover property ($rose(STARTUP));
  cover property ($rose(INIT_OE));
endmodule // csl_checker
`default_nettype wire

/* csl_src.sv */
// Purpose: Upstream chained device sending serial data
// Assumes: Link clock period 200 ns, idle low
// Notes:   Data changes with the falling edge
`timescale 1ns/10ps
`default_nettype none
module csl_src (
  output logic config_clock,
  output logic din
);
  initial config_clock = 1'b0;
  initial din = 1'b1;
  // Bits out MSB first, one per link clock
  task automatic send(input logic [127:0] v, input int n);
    #5; // Keep link edges off the sampling clock edges
    for (int i = n - 1; i >= 0; i--)
    begin
      din = v[i];
      #100 config_clock = 1'b1;
      #100 config_clock = 1'b0;
    end
    din = ~din;
  endtask
endmodule // csl_src
`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench of the stream loader
// Assumes: Short power-on delay, three 10-bit frames
// Notes:   Slave serial mode fed by the upstream model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int LEN = 93;
  logic        REF_CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PROGRAM_B = 1'b1;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, INIT_O, INIT_OE, MODE_BIT1_O, MODE_BIT1_OE, STARTUP, OSC_OUT_NET, er;
  logic        MODE_BIT0_USER_IN, m0 = 1'b1, m1 = 1'b1, m2 = 1'b1, uo = 1'b0, uoe = 1'b0;
  logic        DOUT, CONFIG_CLOCK_O, CONFIG_CLOCK_OE, PERIPH_READY, wr_b = 1'b1;
  logic [7:0]  pdat = 8'h00;
  wire logic   config_clock, din, init_w, m1_w;
  int          errors = 0, n_checks = 0, dfalls = 0;
  // Init pulled up; mode pin 1 shared with user drive
  assign init_w = INIT_OE ? INIT_O : 1'b1;
  assign m1_w = MODE_BIT1_OE ? MODE_BIT1_O : m1;
  csl_top #(.POR_CYCLES(200), .FRAME_BITS(10), .NUM_FRAMES(3)) dut (
    .REF_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .PROGRAM_B,
    .INIT_I(init_w), .INIT_O, .INIT_OE, .MODE_BIT0_I(m0), .MODE_BIT1_I(m1_w), .MODE_BIT2_I(m2), .MODE_BIT1_O,
    .MODE_BIT1_OE, .CONFIG_CLOCK_I(config_clock), .CONFIG_CLOCK_O, .CONFIG_CLOCK_OE, .DIN(din), .DOUT,
    .DATA_IN(pdat), .PROM_ADDR(), .PERIPH_WR_B(wr_b), .PERIPH_READY, .STARTUP, .OSC_OUT_NET,
    .DIVIDER_TAP_A(), .DIVIDER_TAP_B(), .MODE_BIT0_USER_IN, .MODE_BIT2_USER_IN(),
    .MODE_BIT1_USER_OUT(uo), .MODE_BIT1_USER_OE(uoe));
  csl_src src (.config_clock, .din);
  // 40 MHz clock
  always #12.5 REF_CLK = ~REF_CLK;
  // Falling edges of the chain output
  always @(negedge DOUT) dfalls++;
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s exp %h got %h", what, exp, got);
      errors++;
    end
  endtask
  // APB transfer, waits for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1 && ++t < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic osc_highs(output int c);
    c = 0;
    repeat (3) @(posedge REF_CLK);
    repeat (10) @(posedge REF_CLK) c += OSC_OUT_NET;
  endtask
  // Wait for init release, then one stream
  task automatic load(input logic [3:0] ck);
    int t = 0;
    while (INIT_OE !== 1'b0 && t++ < 5000) @(posedge REF_CLK);
    chk("init release", 1, t < 5000);
    src.send({35'h0, 8'hff, 4'h2, 24'(LEN), 4'hf, {3{1'b0, 10'h155, ck}}, 8'hff}, LEN);
    @(posedge REF_CLK);
  endtask
  task automatic test_regs;
    int c;
    chk("clear", 1, INIT_OE);
    apb(0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h10, rd);
    apb(0, 12'h010, 32'h0);
    chk("unmapped", 1, er);
    apb(1, 12'h000, 32'h11);
    osc_highs(c);
    chk("osc on", 4, c);
    apb(1, 12'h000, 32'h10);
    osc_highs(c);
    chk("osc off", 0, c);
    $display("test regs done");
  endtask
  task automatic test_load;
    load(4'h6);
    apb(0, 12'h004, 32'h0);
    chk("mode", 5, 32'(rd[6:4]));
    repeat (200) if (STARTUP !== 1'b1) @(posedge REF_CLK);
    chk("startup", 1, STARTUP);
    apb(0, 12'h008, 32'h0);
    chk("length", LEN, rd);
    chk("dout falls", 4, dfalls);
    chk("user in high", 1, MODE_BIT0_USER_IN);
    m0 <= 1'b0;
    uoe <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    chk("user in", 0, MODE_BIT0_USER_IN);
    chk("user oe", 1, MODE_BIT1_OE);
    $display("test load done");
  endtask
  task automatic test_err;
    PROGRAM_B <= 1'b0;
    m0 <= 1'b1;
    uoe <= 1'b0;
    repeat (400) @(posedge REF_CLK);
    chk("held clear", 1, INIT_OE);
    PROGRAM_B <= 1'b1;
    load(4'h5);
    repeat (20) @(posedge REF_CLK);
    chk("init low", 1, INIT_OE);
    chk("no startup", 0, STARTUP);
    apb(0, 12'h004, 32'h0);
    chk("err state", 32'h106, rd & 32'h30f);
    $display("test err done");
  endtask
  // Program pulse, then wait for init release in mode {bit2,bit1,bit0}
  task automatic restart(input logic [2:0] m);
    int t = 0;
    {m2, m1, m0} <= m;
    PROGRAM_B <= 1'b0;
    repeat (20) @(posedge REF_CLK);
    PROGRAM_B <= 1'b1;
    while (INIT_OE !== 1'b0 && t++ < 5000) @(posedge REF_CLK);
    chk("restart", 1, t < 5000);
  endtask
  task automatic test_master;
    int c = 0;
    restart(3'h0);
    repeat (1900) @(posedge REF_CLK);
    chk("clock held", 0, CONFIG_CLOCK_OE);
    repeat (200) @(posedge REF_CLK);
    chk("clock on", 1, CONFIG_CLOCK_OE);
    repeat (20) @(posedge REF_CLK) c += CONFIG_CLOCK_O;
    chk("clock rate", 10, c);
    $display("test master done");
  endtask
  task automatic test_periph;
    int c = 0;
    restart(3'h5);
    repeat (10) @(posedge REF_CLK);
    chk("ready", 1, PERIPH_READY);
    pdat <= 8'hf2;
    wr_b <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    wr_b <= 1'b1;
    chk("busy", 0, PERIPH_READY);
    repeat (100) @(posedge REF_CLK) c += CONFIG_CLOCK_O;
    chk("clock burst", 40, c);
    chk("ready again", 1, PERIPH_READY);
    $display("test periph done");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (20) @(posedge REF_CLK);
    test_regs();
    test_load();
    test_err();
    test_master();
    test_periph();
    test_done();
  end
  // Tests take about 120 us; allow far more
  initial
  begin
    #500us;
    errors++;
    test_done();
  end
endmodule // testbench
bind csl_top csl_checker u_chk (.REF_CLK, .RST_B, .PSEL, .PENABLE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .INIT_O, .INIT_OE, .STARTUP, .MODE_BIT0_USER_IN, .MODE_BIT1_OE);
`default_nettype wire
